// ===== stepper_pkg.sv
package stepper_pkg;
   // Clock and oscillator rates
   localparam int CLK_HZ = 50_000_000;
   localparam int OSC_HZ_DEF = 30_000;
   localparam int OSC_CYC_DEF = CLK_HZ / OSC_HZ_DEF;
   localparam logic [15:0] OSC_PERIOD_DEF = 16'(OSC_CYC_DEF);
   // Hold time-out, stands in for the RC delay
   localparam int HOLD_TIME_US = 10_000;
   localparam int HOLD_CYC_DEF = HOLD_TIME_US * (CLK_HZ / 1_000_000);
   localparam logic [23:0] HOLD_DELAY_DEF = 24'(HOLD_CYC_DEF);

   // Register byte offsets
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_OSC = 4'h4;
   localparam logic [3:0] ADR_HOLD = 4'h8;
   localparam logic [3:0] ADR_STAT = 4'hc;

   // Control register fields
   localparam int CTRL_DIR = 0;
   localparam int CTRL_HALF = 1;
   localparam int CTRL_EN = 2;
   localparam int CTRL_CHOP_PH = 3;
   localparam int CTRL_RIPPLE = 4;
   localparam int CTRL_OSC_EXT = 5;
   localparam logic [7:0] CTRL_RST = 8'h11;

   // Status register fields
   localparam int STAT_IDX_LSB = 0;
   localparam int STAT_HOME = 3;
   localparam int STAT_LATCH_LSB = 4;
   localparam int STAT_REF_HOLD = 6;
   localparam int STAT_SCALE = 7;

   // Synchronised input bits and their idle levels
   localparam int SYNC_W = 6;
   localparam int IN_STEP = 0;
   localparam int IN_RSTN = 1;
   localparam int IN_SYNC = 2;
   localparam int IN_TRIP_AB = 3;
   localparam int IN_TRIP_CD = 4;
   localparam int IN_HOLD = 5;
   localparam logic [5:0] IN_RST_LVL = 6'h27;

   // Translator
   localparam logic [2:0] HOME_IDX = 3'h0;
   localparam logic [3:0] HOME_PATTERN = 4'h5;

   typedef enum logic [1:0] {
      REF_STEP = 2'b01,
      REF_HOLD = 2'b10
   } ref_mode_e;
endpackage

// ===== input_sync.sv
`timescale 1ns/1ps
module input_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [stepper_pkg::SYNC_W-1:0] async_i,
   output logic [stepper_pkg::SYNC_W-1:0] level_o
);
   typedef struct packed {
      logic [stepper_pkg::SYNC_W-1:0] ff1;
      logic [stepper_pkg::SYNC_W-1:0] ff2;
      logic [stepper_pkg::SYNC_W-1:0] ff3;
      logic [stepper_pkg::SYNC_W-1:0] lvl;
   } sync_s;

   sync_s s_r;
   sync_s s_nxt;
   logic [stepper_pkg::SYNC_W-1:0] agree;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ff1 = async_i;
      s_nxt.ff2 = s_r.ff1;
      s_nxt.ff3 = s_r.ff2;
      // Level moves only when two late stages agree
      agree = ~(s_r.ff2 ^ s_r.ff3);
      s_nxt.lvl = (s_r.ff2 & agree) | (s_r.lvl & ~agree);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.ff1 <= stepper_pkg::IN_RST_LVL;
         s_r.ff2 <= stepper_pkg::IN_RST_LVL;
         s_r.ff3 <= stepper_pkg::IN_RST_LVL;
         s_r.lvl <= stepper_pkg::IN_RST_LVL;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level_o = s_r.lvl;
endmodule

// ===== stepper_ctrl.sv
// Contract
// RQ1: One step per rising end of step pulse
// RQ2: Direction high forward, low reverse
// RQ3: Reset pin low forces home 0101
// RQ4: Home indicator released at pattern 0101
// RQ5: Half select high half, low full
// RQ6: Full at even/odd state picks wave/normal; the code drives normal (two-phase) from even states, wave from odd
// RQ7: Enable low drives phases, inhibits low
// RQ8: Chop target selects phase or inhibit lines
// RQ9: Phase chop raises the inactive pair line
// RQ10: Oscillator sets latch, trip clears it
// RQ11: Inhibits active low, AB and CD pairs
// RQ12: Trip one governs AB, two governs CD
// RQ13: Step restarts time-out, then holding reference
// RQ14: Time-out pin low keeps stepping reference
// RQ15: Ripple mode scales two-phase states 70.7%
// RQ16: Internal oscillator pulses drive sync low
// RQ17: External mode takes pulses from sync
// RQ18: Ripple compensation only in half-step
// RQ19: Eight half states, full skips two
// RQ20: Pin inputs synchronised, edges detected once
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module stepper_ctrl #(
   parameter logic [15:0] OSC_PERIOD_RST = stepper_pkg::OSC_PERIOD_DEF,
   parameter logic [23:0] HOLD_DELAY_RST = stepper_pkg::HOLD_DELAY_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic step_n_i,
   input wire logic reset_n_i,
   input wire logic hold_timeout_pin_i,
   input wire logic pair_ab_current_trip_i,
   input wire logic pair_cd_current_trip_i,
   input wire logic sync_i,
   output logic sync_o,
   output logic sync_oe_n_o,
   output logic phase_a_drive_o,
   output logic phase_b_drive_o,
   output logic phase_c_drive_o,
   output logic phase_d_drive_o,
   output logic pair_ab_inhibit_n_o,
   output logic pair_cd_inhibit_n_o,
   output logic home_o,
   output logic home_oe_n_o,
   output logic holding_reference_sel_o,
   output logic ref_scale_707_o
);
   typedef struct packed {
      logic [5:0] prev;
      logic [2:0] idx;
      logic [1:0] latch;
      logic [15:0] osc_cnt;
      logic osc_pulse;
      logic [23:0] hold_cnt;
      stepper_pkg::ref_mode_e ref_mode;
      logic [7:0] ctrl;
      logic [15:0] osc_period;
      logic [23:0] hold_delay;
      logic ack;
      logic [31:0] rdat;
      logic [3:0] ph;
      logic [1:0] inh_n;
      logic home_oe_n;
      logic sync_out;
      logic sync_oe_n;
      logic ref_hold;
      logic ref_scale;
   } ctrl_s;

   ctrl_s s_r;
   ctrl_s s_nxt;
   logic [5:0] lvl;
   logic step_ev;
   logic step_acc;
   logic sync_fall;
   logic [1:0] trip;
   logic [2:0] delta;
   logic [2:0] step_target;
   logic [5:0] pat;
   logic pulse;
   logic [31:0] wr;

   function automatic logic [5:0] phase_pattern(input logic [2:0] idx);
      // Bits: AB on, CD on, then phases A, B, C, D
      case (idx)
         3'h0: phase_pattern = 6'h35;
         3'h1: phase_pattern = 6'h11;
         3'h2: phase_pattern = 6'h39;
         3'h3: phase_pattern = 6'h28;
         3'h4: phase_pattern = 6'h3a;
         3'h5: phase_pattern = 6'h12;
         3'h6: phase_pattern = 6'h36;
         default: phase_pattern = 6'h24;
      endcase
   endfunction

   function automatic logic [31:0] wb_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   // RQ20: pin synchronisers
   input_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({hold_timeout_pin_i, pair_cd_current_trip_i,
                pair_ab_current_trip_i, sync_i, reset_n_i, step_n_i}),
      .level_o(lvl)
   );

   // RQ1: rising end of step pulse
   assign step_ev = lvl[stepper_pkg::IN_STEP] &
                    ~s_r.prev[stepper_pkg::IN_STEP];
   assign step_acc = step_ev & lvl[stepper_pkg::IN_RSTN];
   assign sync_fall = ~lvl[stepper_pkg::IN_SYNC] &
                      s_r.prev[stepper_pkg::IN_SYNC];
   // RQ12: trip one to AB, two to CD
   assign trip = {lvl[stepper_pkg::IN_TRIP_CD],
                  lvl[stepper_pkg::IN_TRIP_AB]};

   // RQ5: half moves one state, full two
   assign delta = s_r.ctrl[stepper_pkg::CTRL_HALF] ? 3'h1 : 3'h2;
   // RQ2: forward adds, reverse subtracts
   assign step_target = s_r.ctrl[stepper_pkg::CTRL_DIR] ?
                        s_r.idx + delta : s_r.idx - delta;
   assign pat = phase_pattern(s_r.idx);

   always_comb begin
      s_nxt = s_r;
      s_nxt.prev = lvl;
      wr = 32'h0000_0000;
      pulse = 1'b0;

      // Bus slave, one wait state, ack dropped after one cycle
      s_nxt.ack = 1'b0;
      if (cyc_i && stb_i && !s_r.ack) begin
         s_nxt.ack = 1'b1;
         s_nxt.rdat = 32'h0000_0000;
         if (we_i) begin
            case (adr_i)
               stepper_pkg::ADR_CTRL: begin
                  wr = wb_merge({24'h00_0000, s_r.ctrl}, dat_i, sel_i);
                  s_nxt.ctrl = wr[7:0];
               end
               stepper_pkg::ADR_OSC: begin
                  wr = wb_merge({16'h0000, s_r.osc_period}, dat_i, sel_i);
                  s_nxt.osc_period = wr[15:0];
               end
               stepper_pkg::ADR_HOLD: begin
                  wr = wb_merge({8'h00, s_r.hold_delay}, dat_i, sel_i);
                  s_nxt.hold_delay = wr[23:0];
               end
               default: begin
                  wr = 32'h0000_0000;
               end
            endcase
         end else begin
            case (adr_i)
               stepper_pkg::ADR_CTRL: begin
                  s_nxt.rdat = {24'h00_0000, s_r.ctrl};
               end
               stepper_pkg::ADR_OSC: begin
                  s_nxt.rdat = {16'h0000, s_r.osc_period};
               end
               stepper_pkg::ADR_HOLD: begin
                  s_nxt.rdat = {8'h00, s_r.hold_delay};
               end
               stepper_pkg::ADR_STAT: begin
                  s_nxt.rdat[stepper_pkg::STAT_IDX_LSB +: 3] = s_r.idx;
                  s_nxt.rdat[stepper_pkg::STAT_HOME] = s_r.home_oe_n;
                  s_nxt.rdat[stepper_pkg::STAT_LATCH_LSB +: 2] =
                     s_r.latch;
                  s_nxt.rdat[stepper_pkg::STAT_REF_HOLD] = s_r.ref_hold;
                  s_nxt.rdat[stepper_pkg::STAT_SCALE] = s_r.ref_scale;
               end
               default: begin
                  s_nxt.rdat = 32'h0000_0000;
               end
            endcase
         end
      end

      // RQ3: reset pin holds home
      if (!lvl[stepper_pkg::IN_RSTN]) begin
         s_nxt.idx = stepper_pkg::HOME_IDX;
      end else if (step_ev) begin
         // RQ19: full step keeps state parity
         // RQ6: start parity picks drive type
         s_nxt.idx = step_target;
      end

      // RQ17: external pulses are falling sync edges
      if (s_r.ctrl[stepper_pkg::CTRL_OSC_EXT]) begin
         s_nxt.osc_cnt = 16'h0000;
         pulse = sync_fall;
      end else if (s_r.osc_cnt + 16'h0001 >= s_r.osc_period) begin
         s_nxt.osc_cnt = 16'h0000;
         pulse = 1'b1;
      end else begin
         s_nxt.osc_cnt = s_r.osc_cnt + 16'h0001;
      end
      s_nxt.osc_pulse = pulse;
      // RQ16: sync driven low for each pulse
      s_nxt.sync_out = s_r.ctrl[stepper_pkg::CTRL_OSC_EXT] | ~pulse;
      s_nxt.sync_oe_n = s_r.ctrl[stepper_pkg::CTRL_OSC_EXT];

      // RQ10: set wins so a trip cannot swallow a pulse
      for (int p = 0; p < 2; p++) begin
         if (s_r.osc_pulse) begin
            s_nxt.latch[p] = 1'b1;
         end else if (trip[p]) begin
            s_nxt.latch[p] = 1'b0;
         end
      end

      // RQ13: time-out restarts at each step
      case (s_r.ref_mode)
         stepper_pkg::REF_STEP: begin
            if (step_acc) begin
               s_nxt.hold_cnt = s_r.hold_delay;
            end else if (s_r.hold_cnt != 24'h00_0000) begin
               s_nxt.hold_cnt = s_r.hold_cnt - 24'h00_0001;
            end else begin
               s_nxt.ref_mode = stepper_pkg::REF_HOLD;
            end
         end
         stepper_pkg::REF_HOLD: begin
            if (step_acc) begin
               s_nxt.hold_cnt = s_r.hold_delay;
               s_nxt.ref_mode = stepper_pkg::REF_STEP;
            end
         end
         default: begin
            s_nxt.ref_mode = stepper_pkg::REF_STEP;
         end
      endcase
      // RQ14: pin low disables holding mode
      if (!lvl[stepper_pkg::IN_HOLD]) begin
         s_nxt.ref_mode = stepper_pkg::REF_STEP;
         s_nxt.hold_cnt = 24'h00_0000;
      end
      s_nxt.ref_hold = (s_r.ref_mode == stepper_pkg::REF_HOLD);

      // RQ15: two-phase states get reduced reference
      // RQ18: only while half-step selected
      s_nxt.ref_scale = s_r.ctrl[stepper_pkg::CTRL_RIPPLE] &
                        s_r.ctrl[stepper_pkg::CTRL_HALF] &
                        pat[5] & pat[4];

      // RQ4: indicator released at home pattern
      s_nxt.home_oe_n = (pat[3:0] == stepper_pkg::HOME_PATTERN);

      // RQ7: disable overrides everything
      if (!s_r.ctrl[stepper_pkg::CTRL_EN]) begin
         s_nxt.ph = 4'h0;
         s_nxt.inh_n = 2'h0;
      end else if (s_r.ctrl[stepper_pkg::CTRL_CHOP_PH]) begin
         // RQ9: slow decay, inactive line raised
         s_nxt.ph[3] = pat[3] | ~s_r.latch[0];
         s_nxt.ph[2] = pat[2] | ~s_r.latch[0];
         s_nxt.ph[1] = pat[1] | ~s_r.latch[1];
         s_nxt.ph[0] = pat[0] | ~s_r.latch[1];
         s_nxt.inh_n = pat[5:4];
      end else begin
         // RQ8: inhibit chopping, fast decay
         s_nxt.ph = pat[3:0];
         // RQ11: AB and CD inhibits, active low
         s_nxt.inh_n = pat[5:4] & {s_r.latch[0], s_r.latch[1]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.prev <= stepper_pkg::IN_RST_LVL;
         s_r.idx <= stepper_pkg::HOME_IDX;
         s_r.latch <= 2'h0;
         s_r.osc_cnt <= 16'h0000;
         s_r.osc_pulse <= 1'b0;
         s_r.hold_cnt <= 24'h00_0000;
         s_r.ref_mode <= stepper_pkg::REF_STEP;
         s_r.ctrl <= stepper_pkg::CTRL_RST;
         s_r.osc_period <= OSC_PERIOD_RST;
         s_r.hold_delay <= HOLD_DELAY_RST;
         s_r.ack <= 1'b0;
         s_r.rdat <= 32'h0000_0000;
         s_r.ph <= 4'h0;
         s_r.inh_n <= 2'h0;
         s_r.home_oe_n <= 1'b1;
         s_r.sync_out <= 1'b1;
         s_r.sync_oe_n <= 1'b0;
         s_r.ref_hold <= 1'b0;
         s_r.ref_scale <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dat_o = s_r.rdat;
   assign ack_o = s_r.ack;
   assign sync_o = s_r.sync_out;
   assign sync_oe_n_o = s_r.sync_oe_n;
   assign phase_a_drive_o = s_r.ph[3];
   assign phase_b_drive_o = s_r.ph[2];
   assign phase_c_drive_o = s_r.ph[1];
   assign phase_d_drive_o = s_r.ph[0];
   assign pair_ab_inhibit_n_o = s_r.inh_n[1];
   assign pair_cd_inhibit_n_o = s_r.inh_n[0];
   // Open drain: data low, only the enable moves
   assign home_o = 1'b0;
   assign home_oe_n_o = s_r.home_oe_n;
   assign holding_reference_sel_o = s_r.ref_hold;
   assign ref_scale_707_o = s_r.ref_scale;

   a_step_fwd: assert property ( // RQ1
      @(posedge clk_i) disable iff (rst_i)
      step_acc && s_r.ctrl[stepper_pkg::CTRL_DIR] &&
      s_r.ctrl[stepper_pkg::CTRL_HALF]
      |=> s_r.idx == $past(s_r.idx) + 3'h1)
      else $error("step did not advance one state");

   a_step_rev: assert property ( // RQ2
      @(posedge clk_i) disable iff (rst_i)
      step_acc && !s_r.ctrl[stepper_pkg::CTRL_DIR] &&
      s_r.ctrl[stepper_pkg::CTRL_HALF]
      |=> s_r.idx == $past(s_r.idx) - 3'h1)
      else $error("reverse step wrong");

   a_full_two: assert property ( // RQ19
      @(posedge clk_i) disable iff (rst_i)
      step_acc && !s_r.ctrl[stepper_pkg::CTRL_HALF]
      |=> s_r.idx[0] == $past(s_r.idx[0]) &&
          s_r.idx != $past(s_r.idx))
      else $error("full step lost parity");

   a_no_stray: assert property ( // RQ20
      @(posedge clk_i) disable iff (rst_i)
      !step_ev && lvl[stepper_pkg::IN_RSTN] |=> $stable(s_r.idx))
      else $error("state moved without step");

   a_reset_home: assert property ( // RQ3
      @(posedge clk_i) disable iff (rst_i)
      !lvl[stepper_pkg::IN_RSTN] |=> s_r.idx == 3'h0 ##1
      s_r.home_oe_n)
      else $error("reset pin did not reach home");

   a_home_flag: assert property ( // RQ4
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> home_oe_n_o == ($past(s_r.idx) == 3'h0))
      else $error("home indicator wrong");

   a_enable_off: assert property ( // RQ7
      @(posedge clk_i) disable iff (rst_i)
      !s_r.ctrl[stepper_pkg::CTRL_EN] |=> s_r.ph == 4'h0 &&
      !pair_ab_inhibit_n_o && !pair_cd_inhibit_n_o)
      else $error("outputs active while disabled");

   a_phase_chop: assert property ( // RQ9
      @(posedge clk_i) disable iff (rst_i)
      s_r.ctrl[stepper_pkg::CTRL_EN] &&
      s_r.ctrl[stepper_pkg::CTRL_CHOP_PH] && !s_r.latch[1]
      |=> phase_c_drive_o && phase_d_drive_o)
      else $error("phase chop did not raise pair");

   a_inh_chop: assert property ( // RQ8
      @(posedge clk_i) disable iff (rst_i)
      s_r.ctrl[stepper_pkg::CTRL_EN] &&
      !s_r.ctrl[stepper_pkg::CTRL_CHOP_PH] && !s_r.latch[0]
      |=> !pair_ab_inhibit_n_o)
      else $error("inhibit chop missing");

   a_trip_clear: assert property ( // RQ12
      @(posedge clk_i) disable iff (rst_i)
      trip[1] && !s_r.osc_pulse |=> !s_r.latch[1])
      else $error("trip did not clear latch");

   a_osc_set: assert property ( // RQ10
      @(posedge clk_i) disable iff (rst_i)
      s_r.osc_pulse |=> s_r.latch == 2'h3)
      else $error("pulse did not set latches");

   a_hold_off: assert property ( // RQ14
      @(posedge clk_i) disable iff (rst_i)
      !lvl[stepper_pkg::IN_HOLD] |=> ##1 !holding_reference_sel_o)
      else $error("holding reference with pin low");

   a_hold_restart: assert property ( // RQ13
      @(posedge clk_i) disable iff (rst_i)
      step_acc && lvl[stepper_pkg::IN_HOLD]
      |=> s_r.ref_mode == stepper_pkg::REF_STEP &&
          s_r.hold_cnt == $past(s_r.hold_delay))
      else $error("time-out not restarted");

   a_ripple_half: assert property ( // RQ18
      @(posedge clk_i) disable iff (rst_i)
      !s_r.ctrl[stepper_pkg::CTRL_HALF] |=> !ref_scale_707_o)
      else $error("scaling in full step");

   a_ripple_two: assert property ( // RQ15
      @(posedge clk_i) disable iff (rst_i)
      s_r.ctrl[stepper_pkg::CTRL_RIPPLE] &&
      s_r.ctrl[stepper_pkg::CTRL_HALF] && !s_r.idx[0]
      |=> ref_scale_707_o)
      else $error("two-phase state not scaled");

   a_sync_pulse: assert property ( // RQ16
      @(posedge clk_i) disable iff (rst_i)
      s_r.osc_pulse && !$past(s_r.ctrl[stepper_pkg::CTRL_OSC_EXT])
      |-> !sync_o && !sync_oe_n_o)
      else $error("sync not pulsed low");

   a_sync_in: assert property ( // RQ17
      @(posedge clk_i) disable iff (rst_i)
      s_r.ctrl[stepper_pkg::CTRL_OSC_EXT] && sync_fall
      |=> s_r.osc_pulse ##1 s_r.latch == 2'h3)
      else $error("external sync ignored");
endmodule

// ===== host_stepper.sv
`timescale 1ns/1ps
module host_stepper (
   input wire logic clk_i,
   output logic step_n_o,
   output logic reset_n_o,
   output logic sync_low_o
);
   initial begin
      step_n_o = 1'b1;
      reset_n_o = 1'b1;
      sync_low_o = 1'b0;
   end

   // one low pulse
   // Both halves kept long enough for the pin synchroniser
   task automatic step_pulse();
      @(posedge clk_i);
      step_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      step_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask

   task automatic set_reset_n(input logic lvl);
      @(posedge clk_i);
      reset_n_o <= lvl;
      repeat (4) @(posedge clk_i);
   endtask

   // external chop pulse
   // Wire released afterwards, pull-up takes it high
   task automatic sync_pulse();
      @(posedge clk_i);
      sync_low_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sync_low_o <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
endmodule

// ===== stepper_translator_chopper_tb_top.sv
`timescale 1ns/1ps
module stepper_translator_chopper_tb_top;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [5:0] outs;
      logic scale;
   } row_s;

   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
   logic [3:0] adr_i, sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic step_n, reset_n, sync_low, sync_i, sync_o, sync_oe_n_o;
   logic hold_pin, trip_ab, trip_cd, home_o, home_oe_n_o;
   logic pa, pb, pc, pd, ab_n, cd_n, hold_sel, ref_scale_707_o;
   logic [5:0] outs;
   row_s rows [15];
   int err_total = 0;
   int compares = 0;

   assign outs = {pa, pb, pc, pd, ab_n, cd_n};
   // Pull-up on the sync wire when nobody drives it
   assign sync_i = sync_oe_n_o ? ~sync_low : sync_o;

   stepper_ctrl #(
      .OSC_PERIOD_RST(16'h0010),
      .HOLD_DELAY_RST(24'h0028)
   ) stepper_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .step_n_i(step_n),
      .reset_n_i(reset_n), .hold_timeout_pin_i(hold_pin),
      .pair_ab_current_trip_i(trip_ab), .pair_cd_current_trip_i(trip_cd),
      .sync_i(sync_i), .sync_o(sync_o), .sync_oe_n_o(sync_oe_n_o),
      .phase_a_drive_o(pa), .phase_b_drive_o(pb), .phase_c_drive_o(pc),
      .phase_d_drive_o(pd), .pair_ab_inhibit_n_o(ab_n),
      .pair_cd_inhibit_n_o(cd_n), .home_o(home_o),
      .home_oe_n_o(home_oe_n_o), .holding_reference_sel_o(hold_sel),
      .ref_scale_707_o(ref_scale_707_o)
   );

   host_stepper host_stepper_inst (
      .clk_i(clk_i),
      .step_n_o(step_n),
      .reset_n_o(reset_n),
      .sync_low_o(sync_low)
   );

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Classic single cycle, held until ack is seen high
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      // Ack and data sampled at the rising edge that ends the request
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (ack_o !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   task automatic wait_outs(input logic [5:0] e);
      int n;
      n = 0;
      while (outs !== e && n < 80) begin
         @(negedge clk_i);
         n++;
      end
      chk({26'h0, outs}, {26'h0, e});
      if (n >= 80) begin
         tally_and_finish();
      end
   endtask

   task automatic chop_case(input logic [1:0] t, input logic [5:0] e);
      @(posedge clk_i);
      {trip_ab, trip_cd} <= t;
      wait_outs(e);
      @(posedge clk_i);
      {trip_ab, trip_cd} <= 2'b00;
      wait_outs(6'h2b);
   endtask

   initial begin
      int n;
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 4'h0;
      sel_i = 4'hf;
      dat_i = 32'h0000_0000;
      hold_pin = 1'b1;
      trip_ab = 1'b0;
      trip_cd = 1'b0;
      // Half forward round, reverse, then full from odd and even states
      rows = '{'{8'h17, 6'h05, 1'b0}, '{8'h17, 6'h27, 1'b1},
               '{8'h17, 6'h22, 1'b0}, '{8'h17, 6'h2b, 1'b1},
               '{8'h17, 6'h09, 1'b0}, '{8'h17, 6'h1b, 1'b1},
               '{8'h17, 6'h12, 1'b0}, '{8'h17, 6'h17, 1'b1},
               '{8'h16, 6'h12, 1'b0}, '{8'h15, 6'h05, 1'b0},
               '{8'h15, 6'h22, 1'b0}, '{8'h14, 6'h05, 1'b0},
               '{8'h07, 6'h27, 1'b0}, '{8'h15, 6'h2b, 1'b0},
               '{8'h14, 6'h27, 1'b0}};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({26'h0, outs}, 32'h0000_0000);
      chk({26'h0, home_o, home_oe_n_o, sync_oe_n_o, sync_o, hold_sel,
           ref_scale_707_o}, 32'h0000_0014);
      wb(1'b0, 4'h0, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0011);
      wb(1'b0, 4'h4, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0010);
      wb(1'b0, 4'h8, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0028);
      wb(1'b1, 4'h2, 32'hffff_ffff, rd);
      wb(1'b0, 4'h2, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      for (int i = 0; i < 15; i++) begin
         wb(1'b1, 4'h0, {24'h0, rows[i].ctrl}, rd);
         host_stepper_inst.step_pulse();
         wait_outs(rows[i].outs);
         repeat (3) @(negedge clk_i);
         chk({31'h0, ref_scale_707_o}, {31'h0, rows[i].scale});
      end
      wb(1'b1, 4'h0, 32'h0000_0017, rd);
      repeat (60) @(negedge clk_i);
      chk({31'h0, hold_sel}, 32'h0000_0001);
      host_stepper_inst.step_pulse();
      repeat (4) @(negedge clk_i);
      chk({31'h0, hold_sel}, 32'h0000_0000);
      repeat (60) @(negedge clk_i);
      chk({31'h0, hold_sel}, 32'h0000_0001);
      @(posedge clk_i);
      hold_pin <= 1'b0;
      host_stepper_inst.step_pulse();
      repeat (80) @(negedge clk_i);
      chk({31'h0, hold_sel}, 32'h0000_0000);
      n = 0;
      repeat (64) begin
         @(negedge clk_i);
         if (sync_o === 1'b0) begin
            n++;
         end
      end
      chk(32'(n), 32'h0000_0004);
      chk({31'h0, sync_oe_n_o}, 32'h0000_0000);
      wb(1'b1, 4'h0, 32'h0000_0007, rd);
      chop_case(2'b10, 6'h29);
      chop_case(2'b01, 6'h2a);
      wb(1'b1, 4'h0, 32'h0000_000f, rd);
      chop_case(2'b10, 6'h3b);
      chop_case(2'b01, 6'h2f);
      wb(1'b1, 4'h0, 32'h0000_0027, rd);
      repeat (4) @(negedge clk_i);
      chk({31'h0, sync_oe_n_o}, 32'h0000_0001);
      @(posedge clk_i);
      trip_ab <= 1'b1;
      repeat (10) @(posedge clk_i);
      trip_ab <= 1'b0;
      wait_outs(6'h29);
      repeat (40) @(negedge clk_i);
      chk({26'h0, outs}, 32'h0000_0029);
      wb(1'b0, 4'hc, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0024);
      host_stepper_inst.sync_pulse();
      wait_outs(6'h2b);
      chk({31'h0, home_oe_n_o}, 32'h0000_0000);
      wb(1'b1, 4'h0, 32'h0000_0007, rd);
      host_stepper_inst.set_reset_n(1'b0);
      wait_outs(6'h17);
      host_stepper_inst.step_pulse();
      repeat (8) @(negedge clk_i);
      chk({26'h0, outs}, 32'h0000_0017);
      chk({31'h0, home_oe_n_o}, 32'h0000_0001);
      host_stepper_inst.set_reset_n(1'b1);
      wb(1'b1, 4'h0, 32'h0000_0003, rd);
      wait_outs(6'h00);
      tally_and_finish();
   end
endmodule
